// ---- design/cdg_clock_gate.sv ----
/*
 * CPU slowdown divider, fine-resolution PWM disables and per-module
 * clock gates, with an AHB-Lite register slave.
 * Assumes one 100 MHz clock, peripherals consume the enables as clock
 * enables, and present_mask tells which peripherals exist.
 */
// Local design decisions: the AHB-Lite slave port and the register offsets.
// What this block does
// - Slowdown enable bit 11 slows CPU
// - Ratio bits 14:12, 1:1 to 1:128
// - System and peripheral clocks stay full rate
// - CPU enable aligned with peripheral clock
// - Return bit 15: interrupt restores full speed
// - Return bit clear: interrupts change nothing
// - Fine-duty disable stops duty, phase, dead-time
// - Fine-period disable stops period circuitry
// - Fine-period off: period step 8.32 ns
// - Fine-duty off: duty step 8.32 ns
// - Module disable stops all its clocks
// - Gated module ignores writes, reads undefined
// - Active only if clear and present
// - Gate change acts one cycle later
// - First gate register bit map
// - Second gate register: capture and compare
// - Third gate register: comparator, decoder, I2C
// - Unimplemented gate bits read zero
`default_nettype none

module cdg_clock_gate
    import cdg_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // CPU side
    input wire logic irq_pending,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    // Peripheral presence and gates
    input wire cdg_gates_s present_mask,
    output cdg_gates_s module_active,
    output cdg_gates_s module_sfr_en,
    // PWM fine resolution controls
    output cdg_pwm_fine_s pwm_fine_off
);

    logic [15:0] clock_divider_register_reg;
    logic [15:0] gate_a_reg;
    logic [15:0] gate_b_reg;
    logic [15:0] gate_c_reg;
    logic [15:0] aux_reg;
    logic [6:0] slow_cnt_reg;
    logic [6:0] slow_cnt_next;
    logic [6:0] ratio_max;
    logic slow_active;
    cdg_gates_s active_next;
    cdg_bus_e bus_state_reg;
    logic [7:0] addr_reg;
    logic addr_phase;

    assign addr_phase = hsel & hready & htrans[1];

    // Latch address phase; data phase follows with zero wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state_reg <= CDG_BUS_IDLE;
            addr_reg <= 8'h00;
        end else if (hready) begin
            if (addr_phase) begin
                bus_state_reg <= hwrite ? CDG_BUS_WRITE : CDG_BUS_READ;
                addr_reg <= haddr[7:0];
            end else begin
                bus_state_reg <= CDG_BUS_IDLE;
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Register writes; only implemented positions are stored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clock_divider_register_reg <= CDG_CLOCK_DIVIDER_REGISTER_RST;
            gate_a_reg <= CDG_GATE_RST;
            gate_b_reg <= CDG_GATE_RST;
            gate_c_reg <= CDG_GATE_RST;
            aux_reg <= CDG_AUX_RST;
        end else begin
            if (bus_state_reg == CDG_BUS_WRITE) begin
                unique case (addr_reg)
                    CDG_CLOCK_DIVIDER_REGISTER_OFS: begin
                        clock_divider_register_reg <= hwdata[15:0] & CDG_CLOCK_DIVIDER_REGISTER_MASK;
                    end
                    CDG_GATE_A_OFS: begin
                        gate_a_reg <= hwdata[15:0] & CDG_GATE_A_MASK;
                    end
                    CDG_GATE_B_OFS: begin
                        gate_b_reg <= hwdata[15:0] & CDG_GATE_B_MASK;
                    end
                    CDG_GATE_C_OFS: begin
                        gate_c_reg <= hwdata[15:0] & CDG_GATE_C_MASK;
                    end
                    CDG_PWM_AUX_OFS: begin
                        aux_reg <= hwdata[15:0];
                    end
                    default: begin
                    end
                endcase
            end else if (irq_pending && clock_divider_register_reg[CDG_ROI_BIT]
                         && clock_divider_register_reg[CDG_SLOW_EN_BIT]) begin
                // Interrupt drops slowdown only when the return bit is set
                clock_divider_register_reg[CDG_SLOW_EN_BIT] <= 1'b0;
            end
        end
    end

    // Read data from flops; unmapped addresses read zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_phase && !hwrite) begin
            unique case (haddr[7:0])
                CDG_CLOCK_DIVIDER_REGISTER_OFS: hrdata <= {16'h0000, clock_divider_register_reg};
                CDG_GATE_A_OFS: hrdata <= {16'h0000, gate_a_reg};
                CDG_GATE_B_OFS: hrdata <= {16'h0000, gate_b_reg};
                CDG_GATE_C_OFS: hrdata <= {16'h0000, gate_c_reg};
                CDG_PWM_AUX_OFS: hrdata <= {16'h0000, aux_reg};
                CDG_STATUS_OFS: hrdata <= {25'h0, slow_cnt_reg};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Ratio code n divides the CPU enable by 2^n
    assign ratio_max = 7'((8'h01 << clock_divider_register_reg[CDG_RATIO_LSB +: 3]) - 8'h01);
    assign slow_active = clock_divider_register_reg[CDG_SLOW_EN_BIT];

    always_comb begin
        if (!slow_active || slow_cnt_reg >= ratio_max) begin
            slow_cnt_next = 7'h00;
        end else begin
            slow_cnt_next = slow_cnt_reg + 7'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slow_cnt_reg <= 7'h00;
        end else begin
            slow_cnt_reg <= slow_cnt_next;
        end
    end

    // CPU enable pulses on the same edges the peripherals use
    assign cpu_clk_en = !slow_active || (slow_cnt_reg == 7'h00);
    // Peripherals are never slowed
    assign periph_clk_en = 1'b1;

    // Gate change reaches the modules one cycle after the write lands
    assign active_next.gate_a = ~gate_a_reg & present_mask.gate_a & CDG_GATE_A_MASK;
    assign active_next.gate_b = ~gate_b_reg & present_mask.gate_b & CDG_GATE_B_MASK;
    assign active_next.gate_c = ~gate_c_reg & present_mask.gate_c & CDG_GATE_C_MASK;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            module_active <= '0;
        end else begin
            module_active <= active_next;
        end
    end

    // Register access to a gated module is blocked with its clock
    assign module_sfr_en = module_active;

    // A gated PWM block loses its state; software must reprogram it
    generate
        for (genvar g = 0; g < CDG_NUM_PWM; g++) begin : g_pwm
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    pwm_fine_off.fine_period_disable[g] <= 1'b0;
                    pwm_fine_off.fine_duty_disable[g] <= 1'b0;
                end else begin
                    // Coarse step then CDG_COARSE_STEP_PS
                    pwm_fine_off.fine_period_disable[g] <= aux_reg[g];
                    pwm_fine_off.fine_duty_disable[g] <= aux_reg[g+8];
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// ---- design/cdg_pkg.sv ----
/*
 * Package for the CPU slowdown and module clock gate block: register
 * offsets, field positions, reset values and the carrier structs.
 * Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
 */
`default_nettype none

package cdg_pkg;

    // Register byte offsets
    localparam logic [7:0] CDG_CLOCK_DIVIDER_REGISTER_OFS = 8'h00;
    localparam logic [7:0] CDG_GATE_A_OFS = 8'h04;
    localparam logic [7:0] CDG_GATE_B_OFS = 8'h08;
    localparam logic [7:0] CDG_GATE_C_OFS = 8'h0C;
    localparam logic [7:0] CDG_PWM_AUX_OFS = 8'h10;
    localparam logic [7:0] CDG_STATUS_OFS = 8'h14;

    // Clock divider register fields
    localparam int CDG_SLOW_EN_BIT = 11;
    localparam int CDG_RATIO_LSB = 12;
    localparam int CDG_ROI_BIT = 15;

    // Writable masks; unimplemented positions read zero
    localparam logic [15:0] CDG_CLOCK_DIVIDER_REGISTER_MASK = 16'hF800;
    localparam logic [15:0] CDG_GATE_A_MASK = 16'hFEFB;
    localparam logic [15:0] CDG_GATE_B_MASK = 16'h0F0F;
    localparam logic [15:0] CDG_GATE_C_MASK = 16'h0422;

    // Reset values: everything enabled, ratio 1:1
    localparam logic [15:0] CDG_CLOCK_DIVIDER_REGISTER_RST = 16'h0000;
    localparam logic [15:0] CDG_GATE_RST = 16'h0000;
    localparam logic [15:0] CDG_AUX_RST = 16'h0000;

    // Number of PWM generators with fine resolution controls
    localparam int CDG_NUM_PWM = 8;

    // Coarse step in picoseconds when fine resolution is removed
    localparam int CDG_COARSE_STEP_PS = 8320;

    // Gate takes effect one instruction cycle after the write
    localparam int CDG_GATE_DELAY = 1;

    typedef enum logic [1:0] {
        CDG_BUS_IDLE = 2'b00,
        CDG_BUS_WRITE = 2'b01,
        CDG_BUS_READ = 2'b10
    } cdg_bus_e;

    typedef struct packed {
        logic [15:0] gate_a;
        logic [15:0] gate_b;
        logic [15:0] gate_c;
    } cdg_gates_s;

    typedef struct packed {
        logic [CDG_NUM_PWM-1:0] fine_period_disable;
        logic [CDG_NUM_PWM-1:0] fine_duty_disable;
    } cdg_pwm_fine_s;

endpackage

`default_nettype wire

// ---- sim/cdg_chk_asserts.sv ----
/* Port checker for cdg_clock_gate.
   Assumes hready is looped back from hreadyout. */
`default_nettype none
module cdg_chk
    import cdg_pkg::*;
(
    // Bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    // Clocks and gates
    input wire logic irq_pending,
    input wire logic cpu_clk_en,
    input wire logic periph_clk_en,
    input wire cdg_gates_s present_mask,
    input wire cdg_gates_s module_active,
    input wire cdg_gates_s module_sfr_en,
    input wire cdg_pwm_fine_s pwm_fine_off
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic wr;
    logic wq;
    logic [15:0] dv;
    assign wr = hsel && hready && htrans[1] && hwrite;
    // Shadow of the divider, so speed checks need no internal probes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wq <= 1'b0;
            dv <= 16'h0000;
        end else begin
            wq <= wr && haddr[7:0] == CDG_CLOCK_DIVIDER_REGISTER_OFS;
            if (wq) begin
                dv <= hwdata[15:0] & CDG_CLOCK_DIVIDER_REGISTER_MASK;
            end else if (irq_pending && dv[15] && dv[11]) begin
                dv[11] <= 1'b0;
            end
        end
    end
    a_bus_okay: assert property (hreadyout && !hresp && periph_clk_en)
        else $error("bus or peripheral clock unsteady");
    a_sfr_same: assert property (module_sfr_en == module_active)
        else $error("register enable differs from clock");
    a_only_present: assert property ((module_active & ~$past(present_mask)) == '0)
        else $error("absent module running");
    a_gate_a_lag: assert property (wr && haddr[7:0] == CDG_GATE_A_OFS |-> ##3
        module_active.gate_a == (~$past(hwdata[15:0], 2) & CDG_GATE_A_MASK
        & $past(present_mask.gate_a))) else $error("gate A late or wrong");
    a_gate_b_lag: assert property (wr && haddr[7:0] == CDG_GATE_B_OFS |-> ##3
        module_active.gate_b == (~$past(hwdata[15:0], 2) & CDG_GATE_B_MASK
        & $past(present_mask.gate_b))) else $error("gate B late or wrong");
    a_fine_lag: assert property (wr && haddr[7:0] == CDG_PWM_AUX_OFS |-> ##3
        pwm_fine_off == {$past(hwdata[7:0], 2), $past(hwdata[15:8], 2)})
        else $error("fine off wrong");
    a_full_speed: assert property ((!dv[11] || dv[14:12] == 3'd0) |-> cpu_clk_en)
        else $error("cpu slowed while not dozing");
    a_ratio_gap: assert property (dv[11] && dv[14:12] == 3'd2 && cpu_clk_en ##1 $stable(dv)
        |-> !cpu_clk_en) else $error("cpu enable too dense");
    c_slowest: cover property (dv[11] && dv[14:12] == 3'd7 && cpu_clk_en);
    c_wake: cover property (irq_pending && dv[15] && dv[11]);
    c_gate_off: cover property ($fell(module_active.gate_a[9]));
endmodule
bind cdg_clock_gate cdg_chk chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
    .hready, .hreadyout, .hresp, .irq_pending, .cpu_clk_en, .periph_clk_en, .present_mask,
    .module_active, .module_sfr_en, .pwm_fine_off);
`default_nettype wire

// ---- sim/cdg_far_model.sv ----
/* CPU core model: retires on cpu_clk_en, holds an interrupt until served.
   Assumes the bench pulses irq_req for one cycle. */
`default_nettype none
module cdg_far_model (
    // Clock and CPU side
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic cpu_clk_en,
    input wire logic irq_req,
    output logic irq_pending,
    output int cpu_ticks
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cpu_ticks <= 0;
            irq_pending <= 1'b0;
        end else begin
            cpu_ticks <= cpu_ticks + int'(cpu_clk_en);
            // A slowed core takes the request only on its own tick
            irq_pending <= irq_req || (irq_pending && !cpu_clk_en);
        end
    end
endmodule
`default_nettype wire

// ---- sim/cdg_clock_gate_tb.sv ----
/* Bench for cdg_clock_gate with a register model.
   Assumes the checker is bound in and the core model sits beside. */
`default_nettype none
module cdg_clock_gate_tb
    import cdg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk, hresetn, hsel, hwrite, irq_req, hreadyout, hresp, irq_pending, cpu_clk_en;
    logic periph_clk_en;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    cdg_gates_s present_mask, module_active, module_sfr_en;
    cdg_pwm_fine_s pwm_fine_off;
    int mismatches = 0, checks_done = 0, t0, cpu_ticks;
    logic [15:0] regs [5];
    logic [15:0] msk [5] = '{CDG_CLOCK_DIVIDER_REGISTER_MASK, CDG_GATE_A_MASK, CDG_GATE_B_MASK,
        CDG_GATE_C_MASK, 16'hFFFF};
    cdg_clock_gate uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq_pending, .cpu_clk_en,
        .periph_clk_en, .present_mask, .module_active, .module_sfr_en, .pwm_fine_off);
    cdg_far_model far (.hclk, .hresetn, .cpu_clk_en, .irq_req, .irq_pending, .cpu_ticks);
    task chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task wrap_up;
        $display("checks_done %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {16'($urandom), d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        if (w && a < 8'h14) regs[a[4:2]] = d & msk[a[4:2]];
    endtask
    task rdall;
        for (int i = 0; i < 5; i++) begin
            xfer(1'b0, 8'(4 * i), 16'h0000);
            chk(rd, {48'h0, regs[i]});
        end
        xfer(1'b0, 8'h18, 16'h0000);
        chk(rd, 64'h0);
        repeat (2) @(posedge hclk);
        #1 chk(module_active, ~{regs[1], regs[2], regs[3]} & present_mask
            & {CDG_GATE_A_MASK, CDG_GATE_B_MASK, CDG_GATE_C_MASK});
        chk(module_sfr_en, module_active);
        chk(pwm_fine_off, {regs[4][7:0], regs[4][15:8]});
    endtask
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    initial begin
        repeat (20000) @(posedge hclk);
        mismatches++;
        wrap_up();
    end
    initial begin
        void'($urandom(32'hF13E3ECA));
        {hresetn, hsel, hwrite, irq_req, haddr, hwdata, htrans} = '0;
        present_mask = cdg_gates_s'({$urandom, 16'($urandom)});
        foreach (regs[i]) regs[i] = 16'h0000;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdall();
        repeat (12) xfer(1'b1, 8'(4 + 4 * $urandom_range(4)), 16'($urandom));
        rdall();
        // PWM block off and on again, then its fine controls are reprogrammed
        xfer(1'b1, CDG_GATE_A_OFS, 16'h0200);
        xfer(1'b1, CDG_GATE_A_OFS, 16'h0000);
        xfer(1'b1, CDG_PWM_AUX_OFS, 16'($urandom));
        rdall();
        for (int n = 0; n < 8; n++) begin
            xfer(1'b1, CDG_CLOCK_DIVIDER_REGISTER_OFS, 16'(n << 12) | 16'h0800);
            #1 t0 = cpu_ticks;
            repeat (256) @(posedge hclk);
            #1 chk(cpu_ticks - t0, 256 >> n);
        end
        for (int k = 0; k < 2; k++) begin
            xfer(1'b1, CDG_CLOCK_DIVIDER_REGISTER_OFS, k ? 16'hB800 : 16'h3800);
            irq_req <= 1'b1;
            @(posedge hclk);
            irq_req <= 1'b0;
            repeat (20) @(posedge hclk);
            if (k) regs[0][11] = 1'b0;
            rdall();
        end
        wrap_up();
    end
endmodule
`default_nettype wire
